// File: hw/hbc_map.svh
// hbc_map.svh: register offsets, field positions, reset values and timing
// counts of the hardware break condition unit.
// assumes: included by bare name from the package and design modules.
`ifndef HBC_MAP_SVH
`define HBC_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define HBC_OFS_CTRL 8'h00
`define HBC_OFS_OR_SEL 8'h04
`define HBC_OFS_OTH_SEL 8'h08
`define HBC_OFS_DELAY 8'h0C
`define HBC_OFS_SUB_LO 8'h10
`define HBC_OFS_SUB_HI 8'h14
`define HBC_OFS_SEQ_EVT 8'h18
`define HBC_OFS_RST_PT 8'h1C
`define HBC_OFS_PATH0 8'h20
`define HBC_OFS_PATH1 8'h24
`define HBC_OFS_PATH2 8'h28
`define HBC_OFS_FINAL 8'h2C
`define HBC_OFS_TMO 8'h30
`define HBC_OFS_STATUS 8'h34
`define HBC_OFS_MASK 8'h38
`define HBC_OFS_STATE 8'h3C

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define HBC_CTRL_OR_EN 0
`define HBC_CTRL_OTH_EN 1
`define HBC_CTRL_MODE_LSB 2
`define HBC_CTRL_APPLY 5
`define HBC_CTRL_EXC_LSB 8
`define HBC_CTRL_RST 32'h0000_0001

// ----------------------------------------------------------------------
// sequencer, reset point and path fields
// ----------------------------------------------------------------------
`define HBC_SEQ_LEN_LSB 24
`define HBC_RST_PT_EN 4
`define HBC_PATH_W 10
`define HBC_PATH_TMO 4
`define HBC_PATH_FROM 5
`define HBC_PATH_TO 7
`define HBC_PATH_VALID 9

// ----------------------------------------------------------------------
// status bits and timing
// ----------------------------------------------------------------------
`define HBC_ST_MET 0
`define HBC_ST_HALT 1
`define HBC_ROUNDTRIP_NS 10000
`define HBC_CLK_NS 100

`endif

// File: hw/hbc_pkg.sv
// hbc_pkg.sv: types shared by the break condition unit modules.
// assumes: nothing beyond the map header.
package hbc_pkg;
    `include "hbc_map.svh"

    typedef enum logic [2:0] {
        MODE_ACC,
        MODE_SIM,
        MODE_SUB,
        MODE_SEQ,
        MODE_STT
    } hbc_mode_t;

    typedef enum logic [1:0] {
        ST_A,
        ST_B,
        ST_C
    } hbc_st_t;

    localparam int RT_CYC = (`HBC_ROUNDTRIP_NS + `HBC_CLK_NS - 1) /
        `HBC_CLK_NS;
endpackage

// File: hw/hbc_delay.sv
// hbc_delay.sv: shared bus-cycle delay between condition met and halt.
// assumes: one clock per monitored bus cycle; start from same clock.
`timescale 1ns/1ps
module hbc_delay import hbc_pkg::*; #(
    parameter int CNT_W = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic start,
    input wire logic [CNT_W-1:0] delay,
    output logic busy,
    output logic fire
);
    logic [CNT_W-1:0] cnt_reg;
    logic busy_reg;
    logic fire_reg;

    // ------------------------------------------------------------------
    // countdown
    // ------------------------------------------------------------------
    // count then halt
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            fire_reg <= 1'b0;
        end else begin
            fire_reg <= 1'b0;
            if (!busy_reg && start) begin
                if (delay == '0) begin
                    fire_reg <= 1'b1;
                end else begin
                    cnt_reg <= delay;
                    busy_reg <= 1'b1;
                end
            end else if (busy_reg) begin
                if (cnt_reg == CNT_W'(1)) begin
                    busy_reg <= 1'b0;
                    fire_reg <= 1'b1;
                end
                cnt_reg <= cnt_reg - CNT_W'(1);
            end
        end
    end

    assign busy = busy_reg;
    assign fire = fire_reg;
endmodule

// File: hw/hbc_steps.sv
// hbc_steps.sv: sequential and state-transition combination engines.
// assumes: event bits from same clock; clear pulses on apply.
`timescale 1ns/1ps
`include "hbc_map.svh"
module hbc_steps import hbc_pkg::*; #(
    parameter int NEVT = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clear,
    input wire logic seq_en,
    input wire logic stt_en,
    input wire logic [NEVT-1:0] evt,
    input wire logic [23:0] seq_idx,
    input wire logic [2:0] seq_len,
    input wire logic [4:0] rst_pt,
    input wire logic [3*`HBC_PATH_W*3-1:0] paths,
    input wire logic [3:0] final_path,
    input wire logic [15:0] tmo_lim,
    output logic seq_met,
    output logic stt_met,
    output logic [2:0] step,
    output logic [1:0] state
);
    logic [2:0] step_reg;
    hbc_st_t st_reg;
    logic [15:0] tmo_reg;
    logic rst_hit;
    logic step_hit;
    logic timed_out;
    logic [15:0] lim;
    logic path_hit;
    logic [3:0] path_idx;
    logic [1:0] path_to;

    assign rst_hit = rst_pt[`HBC_RST_PT_EN] && evt[rst_pt[3:0]];
    assign step_hit = evt[seq_idx[4*step_reg +: 4]];
    assign lim = (tmo_lim < 16'(RT_CYC)) ? 16'(RT_CYC) : tmo_lim;
    assign timed_out = (tmo_lim != '0) && (tmo_reg >= lim);

    // ------------------------------------------------------------------
    // sequential mode
    // ------------------------------------------------------------------
    // six forward steps
    assign seq_met = seq_en && !rst_hit && step_hit && seq_len != '0 &&
        step_reg == seq_len - 3'(1);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            step_reg <= '0;
        end else if (clear || !seq_en) begin
            step_reg <= '0;
        end else if (rst_hit || seq_met) begin
            step_reg <= '0;
        end else if (step_hit && seq_len != '0 && step_reg < 3'd5) begin
            step_reg <= step_reg + 3'(1);
        end
    end

    // ------------------------------------------------------------------
    // state transitions
    // ------------------------------------------------------------------
    // first matching path
    always_comb begin
        logic [`HBC_PATH_W-1:0] p;
        p = '0;
        path_hit = 1'b0;
        path_idx = '0;
        path_to = '0;
        for (int i = 8; i >= 0; i--) begin
            p = paths[i*`HBC_PATH_W +: `HBC_PATH_W];
            if (p[`HBC_PATH_VALID] &&
                p[`HBC_PATH_FROM +: 2] == 2'(st_reg) &&
                (p[`HBC_PATH_TMO] ? timed_out : evt[p[3:0]])) begin
                path_hit = 1'b1;
                path_idx = 4'(i);
                path_to = p[`HBC_PATH_TO +: 2];
            end
        end
    end

    assign stt_met = stt_en && !rst_hit && path_hit &&
        path_idx == final_path;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_reg <= ST_A;
        end else if (clear || !stt_en || rst_hit) begin
            st_reg <= ST_A;
        end else if (path_hit) begin
            case (path_to)
                2'd0: st_reg <= ST_A;
                2'd1: st_reg <= ST_B;
                2'd2: st_reg <= ST_C;
                default: st_reg <= ST_A;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tmo_reg <= '0;
        end else if (clear || rst_hit || path_hit || !stt_en) begin
            tmo_reg <= '0;
        end else if (tmo_reg != 16'hFFFF) begin
            tmo_reg <= tmo_reg + 16'h0001;
        end
    end

    assign step = step_reg;
    assign state = 2'(st_reg);
endmodule

// File: hw/hbc_top.sv
// hbc_top.sv: hardware break condition unit, Avalon-MM register slave.
// assumes: clk_sys ticks once per monitored bus cycle; event detector
// and exceptional-event inputs come from logic on the same clock.
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "hbc_map.svh"

// Summary of operation
// - sixteen event detector inputs at most
// - delay 0..65535 cycles before halt, default 0
// - or combination met on any selected event
// - or combination enabled after reset
// - one of five other modes, disabled
// - accumulated and: all seen in any order
// - simultaneous and: all in same cycle
// - subroutine: event inside address range
// - sequential: six forward steps plus reset point
// - state transitions: three states, nine paths
// - or, other, exceptional independently enabled
// - per-source enables for exceptional events
// - timeout never shorter than the 10 us round trip, 0 disables
// - settings except the interrupt mask inactive until apply commits them
module hbc_top import hbc_pkg::*; #(
    parameter int NEVT = 16,
    parameter int ADDR_W = 24,
    parameter int NEXC = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NEVT-1:0] evt_det,
    input wire logic [NEXC-1:0] exc_evt,
    input wire logic [ADDR_W-1:0] exec_addr,
    output logic halt_req,
    output logic irq
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic wr_go;
    logic [31:0] ctrl_reg, or_sel_reg, oth_sel_reg, delay_reg;
    logic [31:0] sub_lo_reg, sub_hi_reg, seq_reg, rst_pt_reg;
    logic [31:0] path0_reg, path1_reg, path2_reg, final_reg, tmo_reg;
    logic [31:0] status_reg, mask_reg;
    logic [31:0] a_ctrl_reg, a_or_reg, a_oth_reg, a_delay_reg;
    logic [31:0] a_lo_reg, a_hi_reg, a_seq_reg, a_rst_reg;
    logic [31:0] a_p0_reg, a_p1_reg, a_p2_reg, a_fin_reg, a_tmo_reg;
    logic apply_reg;
    logic halt_reg;
    logic [NEVT-1:0] acc_reg;
    logic [NEVT-1:0] sel;
    hbc_mode_t mode;
    logic oth_en;
    logic or_hit, acc_hit, sim_hit, sub_hit, exc_hit, oth_hit, trig;
    logic seq_met, stt_met, dly_busy, dly_fire;
    logic [2:0] step;
    logic [1:0] state;
    logic [31:0] state_word;

    // merge write data into old value by byte lane
    function automatic logic [31:0] bm(input logic [31:0] old);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i]) begin
                r[8*i +: 8] = avs_writedata[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // bus handshake: one wait state on every access
    // ------------------------------------------------------------------
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign wr_go = avs_write && ack_reg;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    // ------------------------------------------------------------------
    // staged settings
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_reg <= `HBC_CTRL_RST;
            or_sel_reg <= '0;
            oth_sel_reg <= '0;
            delay_reg <= '0;
            sub_lo_reg <= '0;
            sub_hi_reg <= '0;
            seq_reg <= '0;
            rst_pt_reg <= '0;
            path0_reg <= '0;
            path1_reg <= '0;
            path2_reg <= '0;
            final_reg <= '0;
            tmo_reg <= '0;
            mask_reg <= '0;
        end else if (wr_go) begin
            case (avs_address)
                `HBC_OFS_CTRL: ctrl_reg <= bm(ctrl_reg) & 32'h0000_FF1F;
                `HBC_OFS_OR_SEL: or_sel_reg <= bm(or_sel_reg) & 32'h0000_FFFF;
                `HBC_OFS_OTH_SEL: oth_sel_reg <=
                    bm(oth_sel_reg) & 32'h0000_FFFF;
                `HBC_OFS_DELAY: delay_reg <= bm(delay_reg) & 32'h0000_FFFF;
                `HBC_OFS_SUB_LO: sub_lo_reg <= bm(sub_lo_reg);
                `HBC_OFS_SUB_HI: sub_hi_reg <= bm(sub_hi_reg);
                `HBC_OFS_SEQ_EVT: seq_reg <= bm(seq_reg) & 32'h07FF_FFFF;
                `HBC_OFS_RST_PT: rst_pt_reg <= bm(rst_pt_reg) & 32'h0000_001F;
                `HBC_OFS_PATH0: path0_reg <= bm(path0_reg) & 32'h3FFF_FFFF;
                `HBC_OFS_PATH1: path1_reg <= bm(path1_reg) & 32'h3FFF_FFFF;
                `HBC_OFS_PATH2: path2_reg <= bm(path2_reg) & 32'h3FFF_FFFF;
                `HBC_OFS_FINAL: final_reg <= bm(final_reg) & 32'h0000_000F;
                `HBC_OFS_TMO: tmo_reg <= bm(tmo_reg) & 32'h0000_FFFF;
                `HBC_OFS_MASK: mask_reg <= bm(mask_reg) & 32'h0000_0003;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // apply: commit staged settings to the active copy
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            apply_reg <= 1'b0;
        end else begin
            apply_reg <= wr_go && avs_address == `HBC_OFS_CTRL &&
                avs_byteenable[0] && avs_writedata[`HBC_CTRL_APPLY];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            a_ctrl_reg <= `HBC_CTRL_RST;
            a_or_reg <= '0;
            a_oth_reg <= '0;
            a_delay_reg <= '0;
            a_lo_reg <= '0;
            a_hi_reg <= '0;
            a_seq_reg <= '0;
            a_rst_reg <= '0;
            a_p0_reg <= '0;
            a_p1_reg <= '0;
            a_p2_reg <= '0;
            a_fin_reg <= '0;
            a_tmo_reg <= '0;
        end else if (apply_reg) begin
            a_ctrl_reg <= ctrl_reg;
            a_or_reg <= or_sel_reg;
            a_oth_reg <= oth_sel_reg;
            a_delay_reg <= delay_reg;
            a_lo_reg <= sub_lo_reg;
            a_hi_reg <= sub_hi_reg;
            a_seq_reg <= seq_reg;
            a_rst_reg <= rst_pt_reg;
            a_p0_reg <= path0_reg;
            a_p1_reg <= path1_reg;
            a_p2_reg <= path2_reg;
            a_fin_reg <= final_reg;
            a_tmo_reg <= tmo_reg;
        end
    end

    // ------------------------------------------------------------------
    // combinations
    // ------------------------------------------------------------------
    assign sel = a_oth_reg[NEVT-1:0];
    assign mode = hbc_mode_t'(a_ctrl_reg[`HBC_CTRL_MODE_LSB +: 3]);
    assign oth_en = a_ctrl_reg[`HBC_CTRL_OTH_EN];

    assign or_hit = a_ctrl_reg[`HBC_CTRL_OR_EN] &&
        |(evt_det & a_or_reg[NEVT-1:0]);
    assign acc_hit = sel != '0 && ((acc_reg | evt_det) & sel) == sel;
    assign sim_hit = sel != '0 && (evt_det & sel) == sel;
    assign sub_hit = |(evt_det & sel) &&
        exec_addr >= a_lo_reg[ADDR_W-1:0] &&
        exec_addr <= a_hi_reg[ADDR_W-1:0];
    assign exc_hit = |(exc_evt & a_ctrl_reg[`HBC_CTRL_EXC_LSB +: NEXC]);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            acc_reg <= '0;
        end else if (apply_reg || !oth_en || mode != MODE_ACC ||
                     acc_hit) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= acc_reg | (evt_det & sel);
        end
    end

    always_comb begin
        oth_hit = 1'b0;
        if (oth_en) begin
            case (mode)
                MODE_ACC: oth_hit = acc_hit;
                MODE_SIM: oth_hit = sim_hit;
                MODE_SUB: oth_hit = sub_hit;
                MODE_SEQ: oth_hit = seq_met;
                MODE_STT: oth_hit = stt_met;
                default: oth_hit = 1'b0;
            endcase
        end
    end

    hbc_steps #(
        .NEVT(NEVT)
    ) u_steps (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clear(apply_reg),
        .seq_en(oth_en && mode == MODE_SEQ),
        .stt_en(oth_en && mode == MODE_STT),
        .evt(evt_det),
        .seq_idx(a_seq_reg[23:0]),
        .seq_len(a_seq_reg[`HBC_SEQ_LEN_LSB +: 3]),
        .rst_pt(a_rst_reg[4:0]),
        .paths({a_p2_reg[29:0], a_p1_reg[29:0], a_p0_reg[29:0]}),
        .final_path(a_fin_reg[3:0]),
        .tmo_lim(a_tmo_reg[15:0]),
        .seq_met(seq_met),
        .stt_met(stt_met),
        .step(step),
        .state(state)
    );

    // ------------------------------------------------------------------
    // halt request
    // ------------------------------------------------------------------
    // independent sources
    assign trig = or_hit || oth_hit || exc_hit;

    hbc_delay #(
        .CNT_W(16)
    ) u_delay (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(trig && !halt_reg),
        .delay(a_delay_reg[15:0]),
        .busy(dly_busy),
        .fire(dly_fire)
    );

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            halt_reg <= 1'b0;
        end else if (dly_fire) begin
            halt_reg <= 1'b1;
        end else if (apply_reg) begin
            halt_reg <= 1'b0;
        end
    end

    assign halt_req = halt_reg;

    // ------------------------------------------------------------------
    // interrupt status, write one to clear, set wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            status_reg <= '0;
        end else begin
            status_reg[31:2] <= '0;
            status_reg[`HBC_ST_MET] <= (trig && !halt_reg) ||
                (status_reg[`HBC_ST_MET] && !(wr_go &&
                avs_address == `HBC_OFS_STATUS && avs_byteenable[0] &&
                avs_writedata[`HBC_ST_MET]));
            status_reg[`HBC_ST_HALT] <= dly_fire ||
                (status_reg[`HBC_ST_HALT] && !(wr_go &&
                avs_address == `HBC_OFS_STATUS && avs_byteenable[0] &&
                avs_writedata[`HBC_ST_HALT]));
        end
    end

    assign irq = |(status_reg & mask_reg);

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    assign state_word = {6'h00, halt_reg, dly_busy, 2'b00, state, 1'b0,
        step, acc_reg};

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else if (avs_read && !ack_reg) begin
            case (avs_address)
                `HBC_OFS_CTRL: rdata_reg <= ctrl_reg;
                `HBC_OFS_OR_SEL: rdata_reg <= or_sel_reg;
                `HBC_OFS_OTH_SEL: rdata_reg <= oth_sel_reg;
                `HBC_OFS_DELAY: rdata_reg <= delay_reg;
                `HBC_OFS_SUB_LO: rdata_reg <= sub_lo_reg;
                `HBC_OFS_SUB_HI: rdata_reg <= sub_hi_reg;
                `HBC_OFS_SEQ_EVT: rdata_reg <= seq_reg;
                `HBC_OFS_RST_PT: rdata_reg <= rst_pt_reg;
                `HBC_OFS_PATH0: rdata_reg <= path0_reg;
                `HBC_OFS_PATH1: rdata_reg <= path1_reg;
                `HBC_OFS_PATH2: rdata_reg <= path2_reg;
                `HBC_OFS_FINAL: rdata_reg <= final_reg;
                `HBC_OFS_TMO: rdata_reg <= tmo_reg;
                `HBC_OFS_STATUS: rdata_reg <= status_reg;
                `HBC_OFS_MASK: rdata_reg <= mask_reg;
                `HBC_OFS_STATE: rdata_reg <= state_word;
                default: rdata_reg <= '0;
            endcase
        end
    end

    assign avs_readdata = rdata_reg;
endmodule

// File: testbench/hbc_top_asserts.sv
// hbc_top_asserts.sv: port checks of the break condition unit.
// assumes: bound to hbc_top, one clock, sync active-low reset.
`timescale 1ns/1ps
module hbc_top_asserts import hbc_pkg::*; #(
    parameter int NEVT = 16,
    parameter int ADDR_W = 24,
    parameter int NEXC = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [NEVT-1:0] evt_det,
    input wire logic [NEXC-1:0] exc_evt,
    input wire logic [ADDR_W-1:0] exec_addr,
    input wire logic halt_req,
    input wire logic irq
);
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic req;
    assign req = avs_read | avs_write;
    property p_wait_one; req && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("second wait state");
    property p_wait_first; req && !$past(req) |-> avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("no wait state");
    property p_wait_idle; !req |-> !avs_waitrequest; endproperty
    a_wait_idle: assert property (p_wait_idle)
        else $error("wait while idle");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address > 8'h3C
            |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rst_out; $rose(nrst) |-> !halt_req && !irq; endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs high after reset");
    property p_halt_hold;
        $fell(halt_req) |-> $past(avs_write) || $past(avs_write, 2)
            || $past(avs_write, 3);
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt dropped without apply");
    property p_halt_min; $rose(halt_req) |-> halt_req [*3]; endproperty
    a_halt_min: assert property (p_halt_min)
        else $error("halt pulse too short");
    property p_irq_fall;
        $fell(irq) |-> $past(avs_write) || $past(avs_write, 2)
            || $past(avs_write, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without write");
endmodule
bind hbc_top hbc_top_asserts #(.NEVT(NEVT), .ADDR_W(ADDR_W),
    .NEXC(NEXC)) u_asserts (.clk_sys(clk_sys), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .evt_det(evt_det),
    .exc_evt(exc_evt), .exec_addr(exec_addr), .halt_req(halt_req),
    .irq(irq));

// File: testbench/hbc_cpu_model.sv
// hbc_cpu_model.sv: monitored target bus, gives detector pulses.
// assumes: pulse is called just after a clock edge.
`timescale 1ns/1ps
module hbc_cpu_model (
    input wire logic clk_sys,
    output logic [15:0] evt_det,
    output logic [7:0] exc_evt,
    output logic [23:0] exec_addr
);
    initial begin
        evt_det = 16'h0;
        exc_evt = 8'h0;
        exec_addr = 24'h0;
    end
    task automatic pulse(input logic [15:0] e, input logic [7:0] x,
        input logic [23:0] a);
        @(posedge clk_sys);
        evt_det <= e;
        exc_evt <= x;
        exec_addr <= a;
        @(posedge clk_sys);
        evt_det <= 16'h0;
        exc_evt <= 8'h0;
        exec_addr <= ~a;
    endtask
endmodule

// File: testbench/tb.sv
// tb.sv: self-checking bench of the break condition unit.
// assumes: hbc_top, hbc_cpu_model and the checker are compiled.
`timescale 1ns/1ps
`include "hbc_map.svh"
module tb import hbc_pkg::*;;
    typedef struct {logic [31:0] c; logic [15:0] o, s, d, a, b;
        logic [7:0] x; logic [23:0] p; logic h;} hbc_row_t;
    logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
    logic halt_req, irq;
    logic [7:0] avs_address, exc_evt;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [15:0] evt_det;
    logic [23:0] exec_addr;
    int n_mismatch, checks, tid;
    hbc_row_t rows[13] = '{
        '{32'h1, 16'h104, 0, 0, 0, 16'h100, 0, 0, 1},
        '{32'h0, 16'h104, 0, 0, 0, 16'h100, 0, 0, 0},
        '{32'h2, 0, 16'h8001, 1, 16'h8000, 16'h1, 0, 0, 1},
        '{32'h2, 0, 16'h8001, 1, 0, 16'h1, 0, 0, 0},
        '{32'h6, 0, 16'h8001, 0, 16'h8000, 16'h1, 0, 0, 0},
        '{32'h6, 0, 16'h8001, 5, 0, 16'h8001, 0, 0, 1},
        '{32'hA, 0, 16'h10, 0, 0, 16'h10, 0, 24'h10FF, 1},
        '{32'hA, 0, 16'h10, 0, 0, 16'h10, 0, 24'h1100, 0},
        '{32'hE, 0, 16'h88, 0, 16'h8, 16'h80, 0, 0, 1},
        '{32'hE, 0, 16'h88, 0, 16'h28, 16'h80, 0, 0, 0},
        '{32'h12, 0, 16'h600, 0, 16'h200, 16'h400, 0, 0, 1},
        '{32'h0, 0, 0, 0, 0, 0, 8'hFF, 0, 0},
        '{32'h1, 16'h1, 0, 16'hFFFF, 0, 16'h1, 0, 0, 1}};
    hbc_top DUT (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .evt_det(evt_det), .exc_evt(exc_evt), .exec_addr(exec_addr),
        .halt_req(halt_req), .irq(irq));
    hbc_cpu_model u_cpu (.clk_sys(clk_sys), .evt_det(evt_det),
        .exc_evt(exc_evt), .exec_addr(exec_addr));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [31:0] v);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic run(hbc_row_t r);
        int n;
        acc(1'b1, `HBC_OFS_OR_SEL, {16'h0, r.o});
        acc(1'b1, `HBC_OFS_OTH_SEL, {16'h0, r.s});
        acc(1'b1, `HBC_OFS_DELAY, {16'h0, r.d});
        acc(1'b1, `HBC_OFS_CTRL, r.c | 32'h20);
        u_cpu.pulse(r.a, 8'h0, r.p);
        u_cpu.pulse(r.b, r.x, r.p);
        n = 0;
        while (halt_req !== 1'b1 && n < r.d + 40) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("halt_cycles", r.h ? r.d + 1 : r.d + 40, n);
        tid++;
        $display("test %0d done", tid);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (80000) @(posedge clk_sys);
        n_mismatch++;
        summarize();
    end
    initial begin
        {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        acc(1'b0, `HBC_OFS_CTRL, 32'h0);
        chk("ctrl", 32'h1, d);
        acc(1'b0, `HBC_OFS_DELAY, 32'h0);
        chk("delay", 32'h0, d);
        acc(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, d);
        acc(1'b1, `HBC_OFS_SUB_LO, 32'h1000);
        acc(1'b1, `HBC_OFS_SUB_HI, 32'h10FF);
        acc(1'b1, `HBC_OFS_SEQ_EVT, 32'h200_0073);
        acc(1'b1, `HBC_OFS_RST_PT, 32'h15);
        acc(1'b1, `HBC_OFS_PATH0, 32'hCAA89);
        acc(1'b1, `HBC_OFS_FINAL, 32'h1);
        acc(1'b1, `HBC_OFS_MASK, 32'h1);
        foreach (rows[i]) run(rows[i]);
        for (int i = 0; i < 8; i++)
            run('{32'h100 << i, 0, 0, 0, 0, 0, 8'h1 << i, 0, 1});
        acc(1'b1, `HBC_OFS_OR_SEL, 32'h1);
        acc(1'b1, `HBC_OFS_CTRL, 32'h21);
        acc(1'b1, `HBC_OFS_OR_SEL, 32'h2);
        u_cpu.pulse(16'h2, 8'h0, 24'h0);
        repeat (4) @(posedge clk_sys);
        chk("halt", 32'h0, {31'h0, halt_req});
        u_cpu.pulse(16'h1, 8'h0, 24'h0);
        repeat (2) @(posedge clk_sys);
        chk("halt", 32'h1, {31'h0, halt_req});
        chk("irq", 32'h1, {31'h0, irq});
        acc(1'b1, `HBC_OFS_MASK, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        acc(1'b1, `HBC_OFS_MASK, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        acc(1'b1, `HBC_OFS_STATUS, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        summarize();
    end
endmodule
